/* File: pwm_pkg.sv */
// Constants, types and register map of the six-channel pulse-width modulator.
// Assumes a single 250 MHz system clock and a byte-wide register port.
//
// Operation
// R01: Six channels, each with its own 16-bit duty; one shared 16-bit period.
// R02: Duty compares over 65536 steps counted in selected PWM clock cycles.
// R03: PWM clock selects system clock, 16 MHz oscillator or doubled 32 MHz.
// R04: Upper byte writes act directly; lower byte writes go to shared holding buffer.
// R05: Upper byte write commits buffered low byte; upper byte read loads it.
// R06: Software writes low then high, reads high then low.
// R07: Clearing global enable clears and stops all channels; set keeps them running.
// R08: Channel output goes low when base counter equals its duty.
// R09: At period start every running channel output goes high until match.
// R10: Base counter counts zero to period then restarts; period plus one cycles.
// R11: New period and duty apply at once after the upper byte write.
// R12: One shared flag set at every base counter rollover.
// R13: Only channel 0 has dead time and a complementary pair; others plain.
// R14: Channel 0 pair has four output forms; the first after reset.
// R15: Programmable gap of 0 to 15 PWM clocks between pair edges.
// R16: Clock select codes 00 and 01 system, 10 oscillator, 11 doubled.
// R17: Output form codes 00 to 11 pick first to fourth form.
// R18: Dead-time zero inserts no gap; N inserts N PWM clocks.
// R19: Writing FDh to the flag register clears the period flag only.
package pwm_pkg;
    localparam int CHANNELS = 6;
    localparam logic [7:0] IE_ADDR = 8'h0D;
    localparam logic [7:0] IF_ADDR = 8'h0E;
    localparam logic [7:0] CTRL_ADDR = 8'h89;
    localparam logic [7:0] ICLR_ADDR = 8'h8A;
    localparam logic [7:0] OPT_ADDR = 8'h91;
    localparam logic [7:0] PRDH_ADDR = 8'h92;
    localparam logic [7:0] PRDL_ADDR = 8'h93;
    localparam logic [7:0] DUTY_BASE = 8'h94;
    localparam logic [7:0] DUTY_END = 8'hA0;
    localparam int EN_BIT = 7;
    localparam int FORM_LSB = 4;
    localparam int DZ_LSB = 0;
    localparam int CKS_LSB = 4;
    localparam int FLAG_BIT = 1;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] DUTY_RESET = 16'h8000;
    localparam logic [1:0] CKS_OSC_DOUBLE = 2'h3;
    localparam int SYS_CLK_MHZ = 250;
    localparam int OSC_MHZ = 16;
    localparam logic [8:0] ACC_MOD = 9'(SYS_CLK_MHZ);
    localparam logic [8:0] OSC_STEP = 9'(OSC_MHZ);
    localparam logic [8:0] OSC2_STEP = 9'(2 * OSC_MHZ);

    typedef enum logic [1:0] {
        FORM_COMPL,
        FORM_INV,
        FORM_POS_ONLY,
        FORM_SWAP
    } out_form_t;

    typedef enum logic {
        GAP_IDLE,
        GAP_WAIT
    } gap_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage

/* File: dead_gap_gen.sv */
// Dead-time generator and output former for the channel 0 pair.
// Assumes raw_i changes only on PWM clock ticks and run_i low parks it.
`timescale 1ns/1ns
`default_nettype none
module dead_gap_gen import pwm_pkg::*; (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic raw_i,
    input wire logic [1:0] form_i,
    input wire logic [3:0] width_i,
    output logic pos_o,
    output logic neg_o
);
    gap_state_t state;
    logic lvl;
    logic [3:0] left;
    logic act_p;
    logic act_n;

    // Every edge of the raw wave holds both sides off for width_i ticks.
    always_ff @(posedge clock_i) begin
        if (!resetn_i || !run_i) begin
            state <= GAP_IDLE;
            lvl <= 1'b0;
            left <= 4'h0;
        end else begin
            case (state)
                GAP_IDLE: begin
                    if (raw_i != lvl) begin
                        if (width_i == 4'h0) begin
                            lvl <= raw_i; // R18
                        end else begin
                            state <= GAP_WAIT; // R15
                            left <= width_i;
                        end
                    end
                end
                GAP_WAIT: begin
                    if (tick_i) begin
                        left <= left - 4'h1;
                        if (left == 4'h1) begin
                            state <= GAP_IDLE; // R18
                            lvl <= raw_i;
                        end
                    end
                end
                default: state <= GAP_IDLE;
            endcase
        end
    end

    // Active levels of the two sides, both off during a gap.
    assign act_p = lvl && (state == GAP_IDLE); // R13
    assign act_n = !lvl && (state == GAP_IDLE);

    // Output form; a stopped pair always rests low whatever the form.
    always_ff @(posedge clock_i) begin
        if (!resetn_i || !run_i) begin
            pos_o <= 1'b0;
            neg_o <= 1'b0;
        end else begin
            case (out_form_t'(form_i)) // R17
                FORM_COMPL: begin
                    pos_o <= act_p; // R14
                    neg_o <= act_n;
                end
                FORM_INV: begin
                    pos_o <= !act_p;
                    neg_o <= !act_n;
                end
                FORM_POS_ONLY: begin
                    pos_o <= act_p;
                    neg_o <= 1'b0;
                end
                FORM_SWAP: begin
                    pos_o <= act_n;
                    neg_o <= act_p;
                end
                default: begin
                    pos_o <= 1'b0;
                    neg_o <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    property p_gap_quiet;
        run_i && state == GAP_WAIT && form_i == 2'h0 |=> !pos_o && !neg_o;
    endproperty
    a_gap_quiet: assert property (p_gap_quiet) else $error("pair not quiet in gap"); // R15

    property p_zero_width;
        run_i && state == GAP_IDLE && raw_i != lvl && width_i == 4'h0 |=> lvl == $past(raw_i) && state == GAP_IDLE;
    endproperty
    a_zero_width: assert property (p_zero_width) else $error("gap inserted at zero width"); // R18
endmodule
`default_nettype wire

/* File: pwm_six_channel.sv */
// Top of the six-channel pulse-width modulator with its register port.
// Assumes a same-clock master giving one-cycle read and write strobes.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module pwm_six_channel import pwm_pkg::*; (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire bus_req_t bus_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic ch0_positive_output_o,
    output logic ch0_negative_output_o,
    output logic [CHANNELS-2:0] channel_single_output_o
);
    logic pwm_global_enable;
    logic [1:0] ch0_output_form_select;
    logic [3:0] ch0_dead_time_width;
    logic [1:0] pwm_clock_select;
    logic [15:0] period;
    logic [15:0] duty [CHANNELS];
    logic [7:0] hold;
    logic period_end_flag;
    logic flag_enable;
    logic flag_clear;
    logic [7:0] acc;
    logic [8:0] acc_sum;
    logic [8:0] step;
    logic tick;
    logic [15:0] count;
    logic [15:0] next_count;
    logic started;
    logic rollover;
    logic [CHANNELS-1:0] wave;
    logic [7:0] read_value;
    logic is_duty_access;
    logic [2:0] slot;

    // True for any address inside the duty byte block.
    function automatic logic is_duty(input logic [7:0] a);
        is_duty = (a >= DUTY_BASE) && (a < DUTY_END);
    endfunction

    // Channel number addressed by a duty byte address.
    function automatic logic [2:0] duty_slot(input logic [7:0] a);
        logic [7:0] off;
        off = a - DUTY_BASE;
        duty_slot = off[3:1];
    endfunction

    // Upper bytes sit at even addresses for period and duties alike.
    function automatic logic is_upper(input logic [7:0] a);
        is_upper = !a[0];
    endfunction

    assign is_duty_access = is_duty(bus_i.addr);
    assign slot = duty_slot(bus_i.addr);

    // Fractional tick generator: a phase accumulator approximates the
    // oscillator rates from the system clock, trading a little edge jitter
    // for having only one clock domain in the block.
    always_comb begin
        step = (pwm_clock_select == CKS_OSC_DOUBLE) ? OSC2_STEP : OSC_STEP; // R16
        acc_sum = {1'b0, acc} + step;
    end

    // Tick is a one-cycle pulse per PWM clock period.
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            acc <= 8'h00;
            tick <= 1'b0;
        end else if (!pwm_clock_select[1]) begin
            acc <= 8'h00;
            tick <= 1'b1; // R03
        end else if (acc_sum >= ACC_MOD) begin
            acc <= 8'(acc_sum - ACC_MOD); // R03
            tick <= 1'b1;
        end else begin
            acc <= acc_sum[7:0];
            tick <= 1'b0;
        end
    end

    // A counter at or above a freshly lowered period restarts at once
    // instead of running up to the 16-bit wrap.
    always_comb begin
        rollover = tick && started && (count >= period); // R10 R11
        next_count = rollover ? 16'h0000 : count + 16'h0001;
    end

    // Shared base counter; the first tick after enabling starts a period.
    always_ff @(posedge clock_i) begin
        if (!resetn_i || !pwm_global_enable) begin
            count <= 16'h0000; // R07
            started <= 1'b0;
        end else if (tick) begin
            if (!started) begin
                started <= 1'b1;
            end else begin
                count <= next_count; // R10
            end
        end
    end

    // Raw channel waves: high from period start, low on the duty match.
    // A match wins over the start, so a duty of zero stays low throughout.
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        always_ff @(posedge clock_i) begin
            if (!resetn_i || !pwm_global_enable) begin
                wave[g] <= 1'b0; // R07
            end else if (tick) begin
                if (!started) begin
                    wave[g] <= (duty[g] != 16'h0000); // R09
                end else if (next_count == duty[g]) begin
                    wave[g] <= 1'b0; // R08 R02
                end else if (rollover) begin
                    wave[g] <= 1'b1; // R09
                end
            end
        end
    end

    // Plain outputs of channels 1 to 5 without dead time.
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            channel_single_output_o <= '0;
        end else begin
            channel_single_output_o <= wave[CHANNELS-1:1]; // R13
        end
    end

    // Channel 0 drives the complementary pair through the gap generator.
    dead_gap_gen u_gap (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .run_i(pwm_global_enable),
        .tick_i(tick),
        .raw_i(wave[0]),
        .form_i(ch0_output_form_select),
        .width_i(ch0_dead_time_width),
        .pos_o(ch0_positive_output_o),
        .neg_o(ch0_negative_output_o)
    );

    // Control, period and duty registers with the shared low-byte buffer.
    // A low byte written without its upper byte never reaches the counter.
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            pwm_global_enable <= 1'b0;
            ch0_output_form_select <= 2'h0; // R14
            ch0_dead_time_width <= 4'h0;
            pwm_clock_select <= 2'h0;
            period <= PERIOD_RESET;
            hold <= 8'h00;
            flag_enable <= 1'b0;
            for (int i = 0; i < CHANNELS; i++) begin
                duty[i] <= DUTY_RESET; // R01
            end
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                CTRL_ADDR: begin
                    pwm_global_enable <= bus_i.wdata[EN_BIT]; // R07
                    ch0_output_form_select <= bus_i.wdata[FORM_LSB+:2]; // R17
                    ch0_dead_time_width <= bus_i.wdata[DZ_LSB+:4]; // R15
                end
                OPT_ADDR: pwm_clock_select <= bus_i.wdata[CKS_LSB+:2]; // R16
                PRDH_ADDR: period <= {bus_i.wdata, hold}; // R05 R11
                PRDL_ADDR: hold <= bus_i.wdata; // R04
                IE_ADDR: flag_enable <= bus_i.wdata[FLAG_BIT];
                default: begin
                    if (is_duty_access) begin
                        if (is_upper(bus_i.addr)) begin
                            duty[slot] <= {bus_i.wdata, hold}; // R05 R11
                        end else begin
                            hold <= bus_i.wdata; // R04
                        end
                    end
                end
            endcase
        end else if (bus_i.rd) begin
            if (bus_i.addr == PRDH_ADDR) begin
                hold <= period[7:0]; // R05
            end else if (is_duty_access && is_upper(bus_i.addr)) begin
                hold <= duty[slot][7:0]; // R05
            end
        end
    end

    // Read multiplexer; low bytes always answer from the buffer, so the
    // high-then-low read order is what keeps a word consistent.
    always_comb begin
        read_value = 8'h00;
        case (bus_i.addr)
            CTRL_ADDR: begin
                read_value[EN_BIT] = pwm_global_enable;
                read_value[FORM_LSB+:2] = ch0_output_form_select;
                read_value[DZ_LSB+:4] = ch0_dead_time_width;
            end
            OPT_ADDR: read_value[CKS_LSB+:2] = pwm_clock_select;
            PRDH_ADDR: read_value = period[15:8];
            PRDL_ADDR: read_value = hold; // R06
            IE_ADDR: read_value[FLAG_BIT] = flag_enable;
            IF_ADDR: read_value[FLAG_BIT] = period_end_flag;
            default: begin
                if (is_duty_access) begin
                    read_value = is_upper(bus_i.addr) ? duty[slot][15:8] : hold;
                end
            end
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            rdata_o <= read_value;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Writing a zero at the flag position of the flag register, or a one
    // to the write-only clear register, clears the flag.
    assign flag_clear = bus_i.wr &&
        (((bus_i.addr == IF_ADDR) && !bus_i.wdata[FLAG_BIT]) ||
         ((bus_i.addr == ICLR_ADDR) && bus_i.wdata[FLAG_BIT])); // R19

    // Sticky period-end flag; a rollover in the clearing cycle survives.
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            period_end_flag <= 1'b0;
        end else begin
            period_end_flag <= rollover || (period_end_flag && !flag_clear); // R12 R19
        end
    end

    // Level interrupt, one cycle behind the enabled flag.
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= period_end_flag && flag_enable;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_low_write;
        bus_i.wr && bus_i.addr == PRDL_ADDR;
    endsequence

    sequence s_high_write;
        bus_i.wr && bus_i.addr == PRDH_ADDR;
    endsequence

    property p_low_buffered;
        s_low_write |=> $stable(period) && hold == $past(bus_i.wdata);
    endproperty
    a_low_buffered: assert property (p_low_buffered) else $error("low byte reached period"); // R04

    property p_commit;
        s_low_write ##1 s_high_write |=> period == {$past(bus_i.wdata), $past(bus_i.wdata, 2)};
    endproperty
    a_commit: assert property (p_commit) else $error("period commit wrong"); // R05

    property p_match_low;
        pwm_global_enable && tick && started && next_count == duty[1] |=> !wave[1] ##1 !channel_single_output_o[0];
    endproperty
    a_match_low: assert property (p_match_low) else $error("channel 1 not low at match"); // R08

    property p_restart;
        pwm_global_enable && rollover |=> count == 16'h0000 && period_end_flag;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart or flag at period end"); // R10

    property p_start_high;
        pwm_global_enable && rollover && duty[2] != 16'h0000 |=> wave[2];
    endproperty
    a_start_high: assert property (p_start_high) else $error("channel 2 not high at period start"); // R09

    property p_stopped;
        !pwm_global_enable |=> count == 16'h0000 && wave == '0 ##1 channel_single_output_o == '0;
    endproperty
    a_stopped: assert property (p_stopped) else $error("channels run while disabled"); // R07

    property p_clear_fd;
        bus_i.wr && bus_i.addr == IF_ADDR && bus_i.wdata == 8'hFD && !rollover |=> !period_end_flag;
    endproperty
    a_clear_fd: assert property (p_clear_fd) else $error("flag not cleared by FD"); // R19

    property p_sys_tick;
        pwm_clock_select == 2'h1 |=> tick;
    endproperty
    a_sys_tick: assert property (p_sys_tick) else $error("system clock select not ticking"); // R16

    // A switch to the doubled rate inside the window may tick sooner, so only
    // ticks still made at the single oscillator rate are held to the spacing.
    property p_osc_rate;
        pwm_clock_select == 2'h2 && tick |=> (!tick || pwm_clock_select != 2'h2) [*8]
            ##1 (!tick || pwm_clock_select != 2'h2);
    endproperty
    a_osc_rate: assert property (p_osc_rate) else $error("oscillator tick too fast"); // R03

    property p_irq;
        period_end_flag && flag_enable |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing"); // R12

    // Port-side checks: idle read data, the shared buffer and control writes.
    property p_rdata_idle;
        !bus_i.rd |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    property p_upper_read_load;
        bus_i.rd && bus_i.addr == PRDH_ADDR |=> hold == $past(period[7:0]);
    endproperty
    a_upper_read_load: assert property (p_upper_read_load) else $error("buffer not loaded by upper read"); // R05

    property p_duty_low_buffered;
        bus_i.wr && is_duty_access && !is_upper(bus_i.addr) |=> hold == $past(bus_i.wdata) && $stable(duty[1]);
    endproperty
    a_duty_low_buffered: assert property (p_duty_low_buffered) else $error("duty low byte not buffered"); // R04

    property p_duty_commit;
        bus_i.wr && bus_i.addr == DUTY_BASE + 8'h02 |=> duty[1] == {$past(bus_i.wdata), $past(hold)};
    endproperty
    a_duty_commit: assert property (p_duty_commit) else $error("duty commit wrong"); // R11

    property p_ctrl_write;
        bus_i.wr && bus_i.addr == CTRL_ADDR |=> pwm_global_enable == $past(bus_i.wdata[EN_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("enable write lost"); // R07

    // Flag and interrupt keep their levels between events.
    property p_flag_sticky;
        period_end_flag && !flag_clear |=> period_end_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without clear"); // R12

    property p_irq_off;
        !(period_end_flag && flag_enable) |=> !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without enabled flag");
endmodule
`default_nettype wire

/* File: pwm_load_model.sv */
// Load model on the PWM pins: counts high cycles per pin and the channel 1 period.
// Assumes the bench frames each measurement with a clear pulse followed by a window.
`timescale 1ns/1ns
`default_nettype none
module pwm_load_model (
    input wire logic clock_i,
    input wire logic clear_i,
    input wire logic window_i,
    input wire logic pos_i,
    input wire logic neg_i,
    input wire logic [4:0] single_i,
    output logic [15:0] pos_cnt_o,
    output logic [15:0] neg_cnt_o,
    output logic [15:0] both_cnt_o,
    output logic [15:0] single_cnt_o [5],
    output logic [15:0] rise_gap_o
);
    logic [15:0] since_rise;
    logic last_single;

    // Both sides high at once would make a half bridge conduct straight through.
    always_ff @(posedge clock_i) begin
        if (clear_i) begin
            pos_cnt_o <= 16'h0000;
            neg_cnt_o <= 16'h0000;
            both_cnt_o <= 16'h0000;
            for (int k = 0; k < 5; k++) begin
                single_cnt_o[k] <= 16'h0000;
            end
        end else if (window_i) begin
            pos_cnt_o <= pos_cnt_o + 16'(pos_i);
            neg_cnt_o <= neg_cnt_o + 16'(neg_i);
            both_cnt_o <= both_cnt_o + 16'(pos_i & neg_i);
            for (int k = 0; k < 5; k++) begin
                single_cnt_o[k] <= single_cnt_o[k] + 16'(single_i[k]);
            end
        end
    end

    // Spacing of channel 1 rising edges is the period that the load sees.
    always_ff @(posedge clock_i) begin
        last_single <= clear_i ? 1'b0 : single_i[0];
        if (clear_i || (single_i[0] && !last_single)) begin
            since_rise <= 16'h0001;
        end else begin
            since_rise <= since_rise + 16'h0001;
        end
        if (single_i[0] && !last_single && !clear_i) begin
            rise_gap_o <= since_rise;
        end
    end
endmodule
`default_nettype wire

/* File: tb_pwm_six_channel.sv */
// Self-checking bench for the six-channel modulator, driven through its register port.
// Assumes the load model beside it and a 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_pwm_six_channel import pwm_pkg::*;;
    logic clock_i = 1'b0;
    logic resetn_i;
    bus_req_t bus;
    logic [7:0] rdata;
    logic irq;
    logic pos;
    logic neg;
    logic [4:0] single;
    logic clear;
    logic window;
    logic [15:0] pos_cnt;
    logic [15:0] neg_cnt;
    logic [15:0] both_cnt;
    logic [15:0] single_cnt [5];
    logic [15:0] rise_gap;
    int mismatches = 0;
    int num_checks = 0;

    pwm_six_channel dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata), .irq_o(irq),
        .ch0_positive_output_o(pos), .ch0_negative_output_o(neg), .channel_single_output_o(single));
    pwm_load_model load_u (.clock_i(clock_i), .clear_i(clear), .window_i(window), .pos_i(pos), .neg_i(neg),
        .single_i(single), .pos_cnt_o(pos_cnt), .neg_cnt_o(neg_cnt), .both_cnt_o(both_cnt),
        .single_cnt_o(single_cnt), .rise_gap_o(rise_gap));

    // Free-running system clock.
    always #2 clock_i = ~clock_i;

    task automatic print_verdict;
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe; the slave never stalls.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock_i);
        bus.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so it is taken there.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock_i);
        bus.rd <= 1'b0;
        #1 check({8'h00, rdata}, {8'h00, exp});
    endtask

    // Low byte first so that the upper write commits a complete value;
    // the two strobes run back to back, as the port allows.
    task automatic wr16(input logic [7:0] hi, input logic [15:0] v);
        @(posedge clock_i);
        bus.addr <= hi + 8'h01;
        bus.wdata <= v[7:0];
        bus.wr <= 1'b1;
        @(posedge clock_i);
        bus.addr <= hi;
        bus.wdata <= v[15:8];
        @(posedge clock_i);
        bus.wr <= 1'b0;
    endtask

    task automatic measure(input int n);
        @(posedge clock_i);
        clear <= 1'b1;
        @(posedge clock_i);
        clear <= 1'b0;
        window <= 1'b1;
        repeat (n) @(posedge clock_i);
        window <= 1'b0;
        @(posedge clock_i);
        #1;
    endtask

    // A hang counts as a mismatch and ends the run the normal way.
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end

    // Main sequence: reset values, byte buffer, waveforms, flag, forms, clock select.
    initial begin
        int ep;
        int en;
        int lo;
        resetn_i = 1'b0;
        bus = '0;
        clear = 1'b1;
        window = 1'b0;
        repeat (5) @(posedge clock_i);
        resetn_i <= 1'b1;
        clear <= 1'b0;
        rd_chk(PRDH_ADDR, 8'hFF);
        rd_chk(PRDL_ADDR, 8'hFF);
        for (int k = 0; k < CHANNELS; k++) begin
            rd_chk(DUTY_BASE + 8'(2 * k), 8'h80);
            rd_chk(DUTY_BASE + 8'(2 * k + 1), 8'h00);
        end
        rd_chk(CTRL_ADDR, 8'h00);
        rd_chk(OPT_ADDR, 8'h00);
        rd_chk(IF_ADDR, 8'h00);
        rd_chk(8'hA5, 8'h00);
        wr16(PRDH_ADDR, 16'h1234);
        wr(PRDL_ADDR, 8'hAA);
        rd_chk(PRDL_ADDR, 8'hAA);
        rd_chk(PRDH_ADDR, 8'h12);
        rd_chk(PRDL_ADDR, 8'h34);
        wr(PRDH_ADDR, 8'h56);
        rd_chk(PRDH_ADDR, 8'h56);
        rd_chk(PRDL_ADDR, 8'h34);
        wr(CTRL_ADDR, 8'h4F);
        rd_chk(CTRL_ADDR, 8'h0F);
        // Period of 8 ticks; duty 0 stays low and duty above the period stays high.
        wr16(PRDH_ADDR, 16'h0007);
        wr16(DUTY_BASE, 16'h0000);
        for (int k = 1; k < 5; k++) begin
            wr16(DUTY_BASE + 8'(2 * k), 16'(k));
        end
        wr16(DUTY_BASE + 8'h0A, 16'h0009);
        wr(CTRL_ADDR, 8'h80);
        measure(8);
        check(pos_cnt, 16'h0000);
        check(neg_cnt, 16'h0008);
        for (int k = 0; k < 4; k++) begin
            check(single_cnt[k], 16'(k + 1));
        end
        check(single_cnt[4], 16'h0008);
        repeat (40) @(posedge clock_i);
        #1 check(rise_gap, 16'h0008);
        check({15'h0000, irq}, 16'h0000);
        rd_chk(IF_ADDR, 8'h02);
        wr(IE_ADDR, 8'h02);
        rd_chk(IE_ADDR, 8'h02);
        check({15'h0000, irq}, 16'h0001);
        wr(CTRL_ADDR, 8'h00);
        repeat (2) @(posedge clock_i);
        #1 check({9'h000, pos, neg, single}, 16'h0000);
        wr(IF_ADDR, 8'hFF);
        rd_chk(IF_ADDR, 8'h02);
        wr(IF_ADDR, 8'hFD);
        rd_chk(IF_ADDR, 8'h00);
        check({15'h0000, irq}, 16'h0000);
        wr(CTRL_ADDR, 8'h80);
        repeat (20) @(posedge clock_i);
        wr(CTRL_ADDR, 8'h00);
        rd_chk(IF_ADDR, 8'h02);
        wr(ICLR_ADDR, 8'h02);
        rd_chk(IF_ADDR, 8'h00);
        rd_chk(ICLR_ADDR, 8'h00);
        // Every output form, without and with the widest gap, over one 40-tick period.
        wr16(PRDH_ADDR, 16'h0027);
        wr16(DUTY_BASE, 16'h0010);
        for (int f = 0; f < 4; f++) begin
            for (int d = 0; d < 16; d += 15) begin
                wr(CTRL_ADDR, 8'h80 | 8'(f << 4) | 8'(d));
                repeat (100) @(posedge clock_i);
                measure(40);
                ep = (f == 1) ? 24 + d : (f == 3) ? 24 - d : 16 - d;
                en = (f == 1) ? 16 + d : (f == 2) ? 0 : (f == 3) ? 16 - d : 24 - d;
                check(pos_cnt, 16'(ep));
                check(neg_cnt, 16'(en));
                check(both_cnt, 16'((f == 1) ? 2 * d : 0));
            end
        end
        // Slower PWM clocks stretch a 4-tick period to 62-63 or 31-32 system cycles.
        wr16(PRDH_ADDR, 16'h0003);
        for (int s = 0; s < 4; s++) begin
            wr(OPT_ADDR, 8'(s << 4));
            repeat (300) @(posedge clock_i);
            #1;
            lo = (s == 2) ? 62 : (s == 3) ? 31 : 4;
            check(16'(rise_gap >= 16'(lo) && rise_gap <= 16'((s < 2) ? lo : lo + 1)), 16'h0001);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
